// File: hdl/sfsr_regs.vh
// Opcodes, field positions, reset values and any-register addresses of the flash status bank.
`ifndef SFSR_REGS_VH
`define SFSR_REGS_VH

`define SFSR_READ_STATUS_ONE_CMD   8'h05
`define SFSR_READ_STATUS_TWO_CMD   8'h07
`define SFSR_READ_CONFIG_ONE_CMD   8'h35
`define SFSR_READ_ANY_REG_CMD      8'h65
`define SFSR_WRITE_ANY_REG_CMD     8'h71
`define SFSR_WRITE_REGISTERS_CMD   8'h01
`define SFSR_SET_WRITE_LATCH_CMD   8'h06
`define SFSR_SET_WRITE_LATCH_V_CMD 8'h50
`define SFSR_CLEAR_WRITE_LATCH_CMD 8'h04
`define SFSR_CLEAR_STATUS_CMD      8'h30
`define SFSR_SUSPEND_CMD           8'h75
`define SFSR_RESET_ARM_CMD         8'h66
`define SFSR_RESET_GO_CMD          8'h99

`define SFSR_ST1_LOCK_BIT   7
`define SFSR_ST1_BOTTOM_BIT 6
`define SFSR_ST1_BP_HI      5
`define SFSR_ST1_BP_LO      2

`define SFSR_ST2_RESET      8'h00

`define SFSR_ST1_VOL_ADDR   24'h800000
`define SFSR_ST2_VOL_ADDR   24'h800001
`define SFSR_CFG_SPAN       8'h08

`define SFSR_KIND_PROGRAM   2'h0
`define SFSR_KIND_SECTOR    2'h1
`define SFSR_KIND_BLOCK     2'h2
`define SFSR_KIND_CHIP      2'h3

`define SFSR_SEL_NONE       2'h0
`define SFSR_SEL_ST1        2'h1
`define SFSR_SEL_ST2        2'h2
`define SFSR_SEL_ZERO       2'h3

`endif

// File: hdl/sfsr_sync.v
// Two flip-flop synchroniser for pin inputs.
`timescale 1ns/1ps
module sfsr_sync #(
	parameter W = 4
) (
	input  wire         clk,
	input  wire         rst_n,
	input  wire [W-1:0] d,
	output reg  [W-1:0] q
);

	reg [W-1:0] meta_q;

	always @(posedge clk) begin
		if (!rst_n) begin
			meta_q <= {W{1'b1}};
			q      <= {W{1'b1}};
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end

endmodule

// File: hdl/sfsr_spi_shift.v
// Mode 0 SPI byte shifter: samples on clock rise, drives out on clock fall.
`timescale 1ns/1ps
module sfsr_spi_shift (
	input  wire       clk,
	input  wire       rst_n,
	input  wire       sck_s,
	input  wire       cs_n_s,
	input  wire       si_s,
	input  wire       load,
	input  wire [7:0] load_byte,
	output reg  [7:0] rx_q,
	output reg        done_q,
	output reg        so_q
);

	reg       sck_q;
	reg [2:0] bit_q;
	reg [6:0] sh_q;
	reg [7:0] tx_q;

	always @(posedge clk) begin
		if (!rst_n) begin
			sck_q  <= 1'b0;
			bit_q  <= 3'h0;
			sh_q   <= 7'h00;
			tx_q   <= 8'h00;
			rx_q   <= 8'h00;
			done_q <= 1'b0;
			so_q   <= 1'b0;
		end else begin
			sck_q  <= sck_s;
			done_q <= 1'b0;
			if (cs_n_s) begin
				bit_q <= 3'h0;
			end else if (sck_s && !sck_q) begin
				sh_q  <= {sh_q[5:0], si_s};
				bit_q <= bit_q + 3'h1;
				if (bit_q == 3'h7) begin
					rx_q   <= {sh_q, si_s};
					done_q <= 1'b1;
				end
			end else if (!sck_s && sck_q) begin
				so_q <= tx_q[7];
				tx_q <= {tx_q[6:0], 1'b0};
			end
			// Load comes a cycle after the byte ends, long before the next clock fall.
			if (load) begin
				tx_q <= load_byte;
			end
		end
	end

endmodule

// File: hdl/sfsr_status_regs.v
// Status register bank of a serial NOR flash, reached through its SPI pins.
// Contract
// - Lock with low protect pin blocks register writes
// - Otherwise registers writable; pin spares other registers
// - Quad modes force internal protect level high
// - Volatile lock follows its nonvolatile default
// - Bottom bit picks protection start address
// - Volatile bottom bit follows its nonvolatile default
// - Four level bits pick protected array portion
// - Program, write, erase need write latch set
// - Enable command sets latch, disable clears it
// - Successful operation clears latch; failure may keep
// - Resets load latch default; register writes spare it; accepted 01h and 71h writes clear it here
// - While busy accept only listed commands
// - Suspend accepted only during array operation
// - Error flags keep busy until clear-status
// - Erase failure or protected erase sets erase error
// - Program failure or protected program sets error
// - Error flags read-only; only clear-status clears
// - Erase-paused flag mirrors erase suspend state
// - Program-paused flag mirrors program suspend state
// - Second status register reserved bits read zero
// - Second status read by 07h and any-read
// - Clear-status 30h also clears write latch
// - First status returned by read command 05h
`timescale 1ns/1ps
`include "sfsr_regs.vh"
module sfsr_status_regs #(
	parameter [7:0] PROGRAM_OPC      = 8'h02,
	parameter [7:0] SECTOR_ERASE_OPC = 8'h20,
	parameter [7:0] BLOCK_ERASE_OPC  = 8'hD8,
	parameter [7:0] CHIP_ERASE_OPC   = 8'h60
) (
	input  wire        CLK,
	input  wire        RST_N,
	input  wire        SCK,
	input  wire        CS_N,
	input  wire        SI,
	output wire        SO,
	output reg         SO_OE,
	input  wire        WP_N,
	input  wire        QUAD_CMD_MODE,
	input  wire        QUAD_IO_MODE,
	input  wire        HW_LOCK_DEFAULT,
	input  wire        PROTECT_FROM_BOTTOM_DEFAULT,
	input  wire [3:0]  BLOCK_PROTECT_DEFAULT,
	input  wire        WRITE_LATCH_DEFAULT,
	input  wire        OP_DONE,
	input  wire        OP_FAIL,
	input  wire        ERASE_PAUSED,
	input  wire        PROGRAM_PAUSED,
	output reg         OP_START,
	output reg  [1:0]  OP_KIND,
	output reg  [23:0] OP_ADDR,
	output reg         SUSPEND_REQ,
	output reg         SOFT_RESET,
	output reg         REG_WR,
	output reg  [23:0] REG_WR_ADDR,
	output reg  [7:0]  REG_WR_DATA,
	output wire        PROTECT_FROM_BOTTOM,
	output wire [3:0]  BLOCK_PROTECT_LEVEL
);

	function busy_ok;
		input [7:0] c;
		begin
			case (c)
				`SFSR_READ_STATUS_ONE_CMD,
				`SFSR_READ_STATUS_TWO_CMD,
				`SFSR_READ_CONFIG_ONE_CMD,
				`SFSR_READ_ANY_REG_CMD,
				`SFSR_SUSPEND_CMD,
				`SFSR_CLEAR_STATUS_CMD,
				`SFSR_RESET_ARM_CMD,
				`SFSR_RESET_GO_CMD: busy_ok = 1'b1;
				default: busy_ok = 1'b0;
			endcase
		end
	endfunction

	function [1:0] any_sel;
		input [23:0] a;
		begin
			if (a == `SFSR_ST1_VOL_ADDR)
				any_sel = `SFSR_SEL_ST1;
			else if (a == `SFSR_ST2_VOL_ADDR)
				any_sel = `SFSR_SEL_ST2;
			else
				any_sel = `SFSR_SEL_ZERO;
		end
	endfunction

	wire       sck_s;
	wire       cs_n_s;
	wire       si_s;
	wire       wp_n_s;
	wire [7:0] rx;
	wire       rx_done;

	reg        cs_n_prev_q;
	reg [7:0]  cmd_q;
	reg [2:0]  nbyte_q;
	reg        ok_q;
	reg [23:0] addr_q;
	reg [7:0]  data_q;
	reg        arm_q;
	reg [1:0]  sel_q;
	reg        ld_q;
	reg        lock_q;
	reg        bottom_q;
	reg [3:0]  bp_q;
	reg        wel_q;
	reg        run_q;
	reg [1:0]  kind_q;
	reg        eerr_q;
	reg        perr_q;
	reg        lock_nv_q;
	reg        bottom_nv_q;
	reg [3:0]  bp_nv_q;
	reg [1:0]  kind_d;

	sfsr_sync #(
		.W(4)
	) u_sync (
		.clk   (CLK),
		.rst_n (RST_N),
		.d     ({SCK, CS_N, SI, WP_N}),
		.q     ({sck_s, cs_n_s, si_s, wp_n_s})
	);

	// A paused operation frees the device, but a latched error keeps it busy.
	wire paused = ERASE_PAUSED | PROGRAM_PAUSED;
	wire operation_in_progress    = (run_q & ~paused) | eerr_q | perr_q;
	wire wp_int = wp_n_s | QUAD_CMD_MODE | QUAD_IO_MODE;
	wire lock_on = lock_q & ~wp_int;

	wire [7:0] st1 = {lock_q, bottom_q, bp_q, wel_q, operation_in_progress};
	wire [7:0] st2 = {1'b0, eerr_q, perr_q, 3'h0, ERASE_PAUSED, PROGRAM_PAUSED};
	wire [7:0] resp = (sel_q == `SFSR_SEL_ST1) ? st1 :
	                  (sel_q == `SFSR_SEL_ST2) ? st2 : 8'h00;

	sfsr_spi_shift u_shift (
		.clk       (CLK),
		.rst_n     (RST_N),
		.sck_s     (sck_s),
		.cs_n_s    (cs_n_s),
		.si_s      (si_s),
		.load      (ld_q),
		.load_byte (resp),
		.rx_q      (rx),
		.done_q    (rx_done),
		.so_q      (SO)
	);

	wire cs_end = cs_n_s & ~cs_n_prev_q;
	wire commit = cs_end & ok_q & (nbyte_q != 3'h0);
	wire is_pe  = (cmd_q == PROGRAM_OPC) || (cmd_q == SECTOR_ERASE_OPC) || (cmd_q == BLOCK_ERASE_OPC);

	// Register writes act at once, so they never raise the busy flag.
	wire go_wrr  = commit && cmd_q == `SFSR_WRITE_REGISTERS_CMD && wel_q && nbyte_q >= 3'h2
	               && !lock_on;
	wire go_write_any_reg_cmd = commit && cmd_q == `SFSR_WRITE_ANY_REG_CMD && wel_q && nbyte_q >= 3'h5
	               && !(lock_on && addr_q[7:0] < `SFSR_CFG_SPAN);
	wire go_arr  = commit && wel_q && ((is_pe && nbyte_q >= 3'h4) || cmd_q == CHIP_ERASE_OPC);
	wire go_susp = commit && cmd_q == `SFSR_SUSPEND_CMD && run_q && !paused;
	wire soft_go = commit && cmd_q == `SFSR_RESET_GO_CMD && arm_q;
	wire wr_st1  = go_wrr || (go_write_any_reg_cmd && addr_q == `SFSR_ST1_VOL_ADDR);

	always @* begin
		if (cmd_q == PROGRAM_OPC)
			kind_d = `SFSR_KIND_PROGRAM;
		else if (cmd_q == SECTOR_ERASE_OPC)
			kind_d = `SFSR_KIND_SECTOR;
		else if (cmd_q == BLOCK_ERASE_OPC)
			kind_d = `SFSR_KIND_BLOCK;
		else
			kind_d = `SFSR_KIND_CHIP;
	end

	assign PROTECT_FROM_BOTTOM = bottom_q;
	assign BLOCK_PROTECT_LEVEL = bp_q;

	// Frame tracking: opcode, byte count, address and data capture, read source.
	always @(posedge CLK) begin
		if (!RST_N) begin
			cs_n_prev_q <= 1'b1;
			cmd_q       <= 8'h00;
			nbyte_q     <= 3'h0;
			ok_q        <= 1'b0;
			addr_q      <= 24'h000000;
			data_q      <= 8'h00;
			arm_q       <= 1'b0;
			sel_q       <= `SFSR_SEL_NONE;
			ld_q        <= 1'b0;
			SO_OE       <= 1'b0;
		end else begin
			cs_n_prev_q <= cs_n_s;
			ld_q        <= rx_done;
			SO_OE       <= ~cs_n_s & (sel_q != `SFSR_SEL_NONE);
			if (commit) begin
				arm_q <= (cmd_q == `SFSR_RESET_ARM_CMD);
			end
			if (cs_n_s) begin
				nbyte_q <= 3'h0;
				sel_q   <= `SFSR_SEL_NONE;
			end else if (rx_done) begin
				if (nbyte_q != 3'h7) begin
					nbyte_q <= nbyte_q + 3'h1;
				end
				if (nbyte_q == 3'h0) begin
					cmd_q <= rx;
					ok_q  <= ~operation_in_progress | busy_ok(rx);
					case (rx)
						`SFSR_READ_STATUS_ONE_CMD: sel_q <= `SFSR_SEL_ST1;
						`SFSR_READ_STATUS_TWO_CMD: sel_q <= `SFSR_SEL_ST2;
						`SFSR_READ_CONFIG_ONE_CMD: sel_q <= `SFSR_SEL_ZERO;
						default: sel_q <= `SFSR_SEL_NONE;
					endcase
				end else begin
					if (nbyte_q < 3'h4) begin
						addr_q <= {addr_q[15:0], rx};
					end
					if (nbyte_q == 3'h1 || nbyte_q == 3'h4) begin
						data_q <= rx;
					end
					if (nbyte_q == 3'h3 && cmd_q == `SFSR_READ_ANY_REG_CMD) begin
						sel_q <= any_sel({addr_q[15:0], rx});
					end
				end
			end
		end
	end

	// Nonvolatile default copies, kept to spot changes in the stored bits.
	always @(posedge CLK) begin
		lock_nv_q   <= HW_LOCK_DEFAULT;
		bottom_nv_q <= PROTECT_FROM_BOTTOM_DEFAULT;
		bp_nv_q     <= BLOCK_PROTECT_DEFAULT;
	end

	// Status state. Error sets are placed after the clear so an error wins a tie.
	always @(posedge CLK) begin
		if (!RST_N || soft_go) begin
			lock_q   <= HW_LOCK_DEFAULT;
			bottom_q <= PROTECT_FROM_BOTTOM_DEFAULT;
			bp_q     <= BLOCK_PROTECT_DEFAULT;
			wel_q    <= WRITE_LATCH_DEFAULT;
			run_q    <= 1'b0;
			kind_q   <= `SFSR_KIND_PROGRAM;
			eerr_q   <= 1'b0;
			perr_q   <= 1'b0;
		end else begin
			if (commit && (cmd_q == `SFSR_SET_WRITE_LATCH_CMD || cmd_q == `SFSR_SET_WRITE_LATCH_V_CMD)) begin
				wel_q <= 1'b1;
			end
			if (commit && cmd_q == `SFSR_CLEAR_WRITE_LATCH_CMD) begin
				wel_q <= 1'b0;
			end
			if (commit && cmd_q == `SFSR_CLEAR_STATUS_CMD) begin
				wel_q  <= 1'b0;
				eerr_q <= 1'b0;
				perr_q <= 1'b0;
			end
			if (wr_st1) begin
				lock_q   <= data_q[`SFSR_ST1_LOCK_BIT];
				bottom_q <= data_q[`SFSR_ST1_BOTTOM_BIT];
				bp_q     <= data_q[`SFSR_ST1_BP_HI:`SFSR_ST1_BP_LO];
			end
			if (go_wrr || go_write_any_reg_cmd) begin
				wel_q <= 1'b0;
			end
			if (go_arr) begin
				run_q  <= 1'b1;
				kind_q <= kind_d;
			end
			if (OP_DONE && run_q) begin
				run_q <= 1'b0;
				if (!OP_FAIL) begin
					wel_q <= 1'b0;
				end else if (kind_q != `SFSR_KIND_PROGRAM) begin
					eerr_q <= 1'b1;
				end else begin
					perr_q <= 1'b1;
				end
			end
			if (HW_LOCK_DEFAULT != lock_nv_q) begin
				lock_q <= HW_LOCK_DEFAULT;
			end
			if (PROTECT_FROM_BOTTOM_DEFAULT != bottom_nv_q) begin
				bottom_q <= PROTECT_FROM_BOTTOM_DEFAULT;
			end
			if (BLOCK_PROTECT_DEFAULT != bp_nv_q) begin
				bp_q <= BLOCK_PROTECT_DEFAULT;
			end
		end
	end

	// Strobes towards the array engine and the other register owners.
	always @(posedge CLK) begin
		if (!RST_N) begin
			OP_START    <= 1'b0;
			OP_KIND     <= `SFSR_KIND_PROGRAM;
			OP_ADDR     <= 24'h000000;
			SUSPEND_REQ <= 1'b0;
			SOFT_RESET  <= 1'b0;
			REG_WR      <= 1'b0;
			REG_WR_ADDR <= 24'h000000;
			REG_WR_DATA <= 8'h00;
		end else begin
			OP_START    <= go_arr;
			SUSPEND_REQ <= go_susp;
			SOFT_RESET  <= soft_go;
			REG_WR      <= go_write_any_reg_cmd && !wr_st1;
			if (go_arr) begin
				OP_KIND <= kind_d;
				OP_ADDR <= addr_q;
			end
			if (go_write_any_reg_cmd) begin
				REG_WR_ADDR <= addr_q;
				REG_WR_DATA <= data_q;
			end
		end
	end

endmodule

// File: tb/sfsr_status_regs_chk.sv
// Port checker for the flash status bank.
`timescale 1ns/1ps
module sfsr_status_regs_chk (
	input wire        CLK,
	input wire        RST_N,
	input wire        CS_N,
	input wire        SO_OE,
	input wire        PROTECT_FROM_BOTTOM_DEFAULT,
	input wire [3:0]  BLOCK_PROTECT_DEFAULT,
	input wire        OP_START,
	input wire        SUSPEND_REQ,
	input wire        SOFT_RESET,
	input wire        REG_WR,
	input wire [23:0] REG_WR_ADDR,
	input wire        PROTECT_FROM_BOTTOM,
	input wire [3:0]  BLOCK_PROTECT_LEVEL
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	property p_start; OP_START |=> !OP_START; endproperty
	a_start: assert property (p_start) else $error("start too long");
	property p_susp; SUSPEND_REQ |=> !SUSPEND_REQ; endproperty
	a_susp: assert property (p_susp) else $error("suspend too long");
	property p_srst; SOFT_RESET |=> !SOFT_RESET; endproperty
	a_srst: assert property (p_srst) else $error("reset pulse too long");
	property p_regwr; REG_WR |=> !REG_WR; endproperty
	a_regwr: assert property (p_regwr) else $error("write pulse too long");
	property p_wra; REG_WR |-> REG_WR_ADDR != 24'h800000; endproperty
	a_wra: assert property (p_wra) else $error("status write leaked");
	property p_btm;
		$changed(PROTECT_FROM_BOTTOM_DEFAULT) |=> PROTECT_FROM_BOTTOM == $past(PROTECT_FROM_BOTTOM_DEFAULT);
	endproperty
	a_btm: assert property (p_btm) else $error("bottom not tracked");
	property p_lvl; $changed(BLOCK_PROTECT_DEFAULT) |=> BLOCK_PROTECT_LEVEL == $past(BLOCK_PROTECT_DEFAULT); endproperty
	a_lvl: assert property (p_lvl) else $error("level not tracked");
	// Five cycles covers the two sync flops plus the output register.
	property p_oe; CS_N [*5] |-> !SO_OE; endproperty
	a_oe: assert property (p_oe) else $error("drive outside frame");
	c_start: cover property (OP_START);
	c_susp: cover property (SUSPEND_REQ);
	c_srst: cover property (SOFT_RESET);
endmodule

// File: tb/sfsr_host.sv
// SPI host model sending mode 0 frames.
`timescale 1ns/1ps
module sfsr_host (
	output logic SCK,
	output logic CS_N,
	output logic SI,
	input  wire  SO
);
	initial begin
		SCK = 1'b0;
		CS_N = 1'b1;
		SI = 1'b0;
	end
	task automatic xf(input int n, input [39:0] t, output [7:0] r);
		int i;
		CS_N = 1'b0;
		for (i = 8 * n - 1; i >= 0; i--) begin
			SI = t[i];
			#62.5 SCK = 1'b1;
			r = {r[6:0], SO};
			#62.5 SCK = 1'b0;
		end
		#62.5 CS_N = 1'b1;
		// Idle data is flipped so sampling outside a frame shows up.
		SI = ~SI;
		#300;
	endtask
endmodule

// File: tb/test_sfsr_status_regs.sv
// Self-checking bench for the flash status bank.
`timescale 1ns/1ps
module test_sfsr_status_regs;
	logic       clk, rst_n, wp_n, qc, qi, lkd, btd, wld, done, fail, esp, psp;
	logic [3:0] bpd;
	wire        sck, cs_n, si, so, so_oe, start, susp, srst, regwr, btm;
	wire [1:0]  kind;
	wire [23:0] addr, wra;
	wire [7:0]  wrd;
	wire [3:0]  bpl;
	logic [7:0] r, starts, susps, srsts, regwrs;
	logic [7:0] ops [4] = '{8'h02, 8'h20, 8'hD8, 8'h60};
	int         cyc, fails, comparisons, k;
	sfsr_host u_host (.SCK(sck), .CS_N(cs_n), .SI(si), .SO(so));
	sfsr_status_regs u_dut (
		.CLK(clk), .RST_N(rst_n), .SCK(sck), .CS_N(cs_n), .SI(si), .SO(so), .SO_OE(so_oe), .WP_N(wp_n),
		.QUAD_CMD_MODE(qc), .QUAD_IO_MODE(qi), .HW_LOCK_DEFAULT(lkd), .PROTECT_FROM_BOTTOM_DEFAULT(btd),
		.BLOCK_PROTECT_DEFAULT(bpd), .WRITE_LATCH_DEFAULT(wld), .OP_DONE(done), .OP_FAIL(fail),
		.ERASE_PAUSED(esp), .PROGRAM_PAUSED(psp), .OP_START(start), .OP_KIND(kind), .OP_ADDR(addr),
		.SUSPEND_REQ(susp), .SOFT_RESET(srst), .REG_WR(regwr), .REG_WR_ADDR(wra), .REG_WR_DATA(wrd),
		.PROTECT_FROM_BOTTOM(btm), .BLOCK_PROTECT_LEVEL(bpl)
	);
	task chk(input [7:0] g, input [7:0] e);
		comparisons++;
		if (g !== e) begin
			fails++;
			$display("BAD %0t got %h want %h", $time, g, e);
		end
	endtask
	task cmd(input int n, input [39:0] t);
		@(negedge clk);
		// The 1.25 ns offset keeps every link edge and the frame end off a rising clock edge.
		#1.25;
		u_host.xf(n, t, r);
		@(negedge clk);
	endtask
	task rd(input [7:0] op, input [7:0] e);
		cmd(2, {op, 8'h00});
		chk(r, e);
	endtask
	task fin(input f);
		@(negedge clk);
		fail = f;
		done = 1'b1;
		@(negedge clk);
		done = 1'b0;
	endtask
	task finish_test;
		$display("fails %0d comparisons %0d", fails, comparisons);
		if (fails == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		// Counting waits for reset, so the unknown strobes before it never reach the counters.
		if (rst_n) begin
			starts <= starts + start;
			susps <= susps + susp;
			srsts <= srsts + srst;
			regwrs <= regwrs + regwr;
		end
		if (cyc == 60000) begin
			fails++;
			finish_test;
		end
	end
	initial begin
		{rst_n, qc, qi, lkd, wld, done, fail, esp, psp} = 9'h000;
		{wp_n, btd, bpd} = 6'h3A;
		{starts, susps, srsts, regwrs} = 32'h0;
		repeat (6) @(negedge clk);
		rst_n = 1'b1;
		repeat (5) @(negedge clk);
		rd(8'h05, 8'h68);
		{esp, psp} = 2'h3;
		rd(8'h07, 8'h03);
		cmd(5, {8'h65, 24'h800001, 8'h00});
		chk(r, 8'h03);
		{esp, psp} = 2'h0;
		rd(8'h07, 8'h00);
		cmd(1, 8'h06);
		rd(8'h05, 8'h6A);
		cmd(1, 8'h04);
		rd(8'h05, 8'h68);
		cmd(4, {8'h02, 24'h123456});
		chk(starts, 8'h00);
		cmd(1, 8'h75);
		chk(susps, 8'h00);
		cmd(1, 8'h06);
		cmd(4, {8'h02, 24'h123456});
		chk(addr[23:16], 8'h12);
		cmd(1, 8'h04);
		rd(8'h05, 8'h6B);
		cmd(1, 8'h75);
		chk(susps, 8'h01);
		fin(1'b0);
		rd(8'h05, 8'h68);
		for (k = 0; k < 4; k++) begin
			cmd(1, 8'h06);
			cmd(k == 3 ? 1 : 4, k == 3 ? {32'h0, ops[k]} : {8'h00, ops[k], 24'h000100});
			chk({6'h00, kind}, k[7:0]);
			fin(1'b1);
			rd(8'h07, k == 0 ? 8'h20 : 8'h40);
			rd(8'h05, 8'h6B);
			cmd(1, 8'h30);
			rd(8'h05, 8'h68);
			rd(8'h07, 8'h00);
		end
		cmd(1, 8'h06);
		cmd(2, {8'h01, 8'hC0});
		rd(8'h05, 8'hC0);
		wp_n = 1'b0;
		cmd(1, 8'h06);
		cmd(2, {8'h01, 8'h3C});
		rd(8'h05, 8'hC2);
		cmd(5, {8'h71, 24'h000110, 8'h5A});
		chk(wrd, 8'h5A);
		chk(wra[7:0], 8'h10);
		chk(regwrs, 8'h01);
		qc = 1'b1;
		cmd(1, 8'h06);
		cmd(2, {8'h01, 8'hBC});
		rd(8'h05, 8'hBC);
		{qc, qi} = 2'h1;
		cmd(1, 8'h06);
		cmd(2, {8'h01, 8'h3C});
		rd(8'h05, 8'h3C);
		{qi, wp_n, lkd, btd, bpd, wld} = 9'h0CB;
		rd(8'h05, 8'h94);
		chk({3'h0, btm, bpl}, 8'h05);
		cmd(1, 8'h99);
		chk(srsts, 8'h00);
		cmd(1, 8'h66);
		cmd(1, 8'h99);
		chk(srsts, 8'h01);
		rd(8'h05, 8'h96);
		finish_test;
	end
endmodule
bind sfsr_status_regs sfsr_status_regs_chk u_chk (
	.CLK(CLK), .RST_N(RST_N), .CS_N(CS_N), .SO_OE(SO_OE), .PROTECT_FROM_BOTTOM_DEFAULT(PROTECT_FROM_BOTTOM_DEFAULT),
	.BLOCK_PROTECT_DEFAULT(BLOCK_PROTECT_DEFAULT), .OP_START(OP_START), .SUSPEND_REQ(SUSPEND_REQ),
	.SOFT_RESET(SOFT_RESET), .REG_WR(REG_WR), .REG_WR_ADDR(REG_WR_ADDR),
	.PROTECT_FROM_BOTTOM(PROTECT_FROM_BOTTOM), .BLOCK_PROTECT_LEVEL(BLOCK_PROTECT_LEVEL)
);
